// ---- logic/spm_pkg.sv ----
// Purpose: constants, register map and carriers of the shared pin mux
// Assumes: avalon-mm slave, 32-bit data, word addressing by byte address
// Notes: two shared pads, normal set or alternate test-port set
package spm_pkg;
   localparam logic [7:0] SPM_OFF_FUNC = 8'h00;
   localparam logic [7:0] SPM_OFF_DIR = 8'h04;
   localparam logic [7:0] SPM_OFF_DOUT = 8'h08;
   localparam logic [7:0] SPM_OFF_DIN = 8'h0C;
   localparam logic [7:0] SPM_OFF_TRIG = 8'h10;
   localparam logic [7:0] SPM_OFF_STAT = 8'h14;
   localparam logic [7:0] SPM_OFF_CLR = 8'h18;
   localparam logic [7:0] SPM_OFF_IEN = 8'h1C;
   localparam logic [7:0] SPM_OFF_PINS = 8'h20;
   // func field: pad six bits 1:0, pad seven bits 3:2
   localparam int SPM_FUNC_W = 2;
   localparam logic [1:0] SPM_FN_GPIO = 2'h0;
   localparam logic [1:0] SPM_FN_IRQ = 2'h1;
   localparam logic [1:0] SPM_FN_CODEC = 2'h2;
   localparam logic [1:0] SPM_FN_DSR = 2'h3;
   // trigger field per pad: 2 bits, pad six 1:0, pad seven 3:2
   localparam logic [1:0] SPM_TRG_LEVEL = 2'h0;
   localparam logic [1:0] SPM_TRG_RISE = 2'h1;
   localparam logic [1:0] SPM_TRG_FALL = 2'h2;
   localparam logic [3:0] SPM_FUNC_RST = 4'h0;
   localparam logic [1:0] SPM_DIR_RST = 2'h0;
   localparam logic [1:0] SPM_DOUT_RST = 2'h0;
   localparam logic [3:0] SPM_TRIG_RST = 4'h0;
   localparam logic [1:0] SPM_IEN_RST = 2'h0;
   localparam logic [31:0] SPM_UNMAPPED = 32'h0000_0000;

   typedef struct packed {
      logic [7:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } spm_bus_req_t;

   typedef struct packed {
      logic [31:0] readdata;
      logic waitrequest;
   } spm_bus_rsp_t;

   typedef struct packed {
      logic [1:0] in;
      logic [1:0] out;
      logic [1:0] oe;
   } spm_pads_t;

   typedef struct packed {
      logic tx_bit;
      logic tx_primary_en;
      logic rx_bit;
      logic rx_alt_sel;
   } spm_codec_t;

   typedef struct packed {
      logic [3:0] func;
      logic [1:0] dir;
      logic [1:0] dout;
      logic [3:0] trig;
      logic [1:0] stat;
      logic [1:0] ien;
      logic [1:0] s1;
      logic [1:0] s2;
      logic [1:0] prev;
      logic bank_s1;
      logic bank_s2;
      logic ack;
      logic [31:0] rdata;
   } spm_state_t;
endpackage : spm_pkg

// ---- logic/spm_shared_pin_mux.sv ----
// Purpose: route two shared pads to irq, gpio, codec, dsr or test reset
// Assumes: pads and bank select are asynchronous to clk_sys
// Notes: avalon slave answers one cycle after the request is seen
//
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
module spm_shared_pin_mux (
   // clock, reset, enable
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clk_en,
   // register bus
   input wire spm_pkg::spm_bus_req_t bus_req,
   output spm_pkg::spm_bus_rsp_t bus_rsp,
   // pads and bank select
   input wire logic pin_bank_select,
   input wire logic [1:0] pad_in,
   output logic [1:0] pad_out,
   output logic [1:0] pad_oe,
   // codec serial port
   input wire logic codec_tx_shift_bit,
   output logic codec_tx_data_alt_en,
   output logic codec_tx_primary_en,
   output logic codec_rx_shift_bit,
   output logic codec_rx_data_alt_sel,
   input wire logic codec_rx_primary_bit,
   // serial data port
   input wire logic dsr_level,
   // test port
   input wire logic trst_primary_n,
   output logic tap_trst_n,
   // interrupts
   output logic [1:0] irq_event,
   output logic irq
);
   import spm_pkg::*;

   spm_state_t q, d;
   logic [1:0] fn6, fn7;
   logic alt;
   logic [1:0] lvl;

   function automatic logic [31:0] spm_pad2(input logic [1:0] v);
      spm_pad2 = {30'h0000_0000, v};
   endfunction : spm_pad2

   function automatic logic [1:0] spm_fn(input logic [3:0] f,
                                         input int p);
      spm_fn = (p == 0) ? f[1:0] : f[3:2];
   endfunction : spm_fn

   assign fn6 = spm_fn(q.func, 0);
   assign fn7 = spm_fn(q.func, 1);
   assign alt = q.bank_s2;

   // pad drivers; alternate set leaves pad six an input
   always_comb begin
      pad_out = 2'h0;
      pad_oe = 2'h0;
      codec_tx_data_alt_en = 1'b0;
      if (!alt) begin
         case (fn6)
            SPM_FN_CODEC: begin
               pad_out[0] = codec_tx_shift_bit;
               pad_oe[0] = 1'b1;
               codec_tx_data_alt_en = 1'b1;
            end
            SPM_FN_DSR: begin
               pad_out[0] = dsr_level;
               pad_oe[0] = 1'b1;
            end
            SPM_FN_GPIO: begin
               pad_out[0] = q.dout[0];
               pad_oe[0] = q.dir[0];
            end
            default: begin
               pad_out[0] = 1'b0;
               pad_oe[0] = 1'b0;
            end
         endcase
         // pad seven has no output function besides general io
         if (fn7 == SPM_FN_GPIO || fn7 == SPM_FN_DSR) begin
            pad_out[1] = q.dout[1];
            pad_oe[1] = q.dir[1];
         end
      end else begin
         // pad seven unused in this block under alternate set; input
         pad_out[1] = 1'b0;
         pad_oe[1] = 1'b0;
      end
   end

   assign codec_tx_primary_en = !codec_tx_data_alt_en;

   // receive path is raw pad level; codec port resamples on its own clock
   assign codec_rx_data_alt_sel = !alt && (fn7 == SPM_FN_CODEC);
   assign codec_rx_shift_bit = codec_rx_data_alt_sel ?
                               pad_in[1] : codec_rx_primary_bit;

   // test reset stays combinational so it acts without any clock
   assign tap_trst_n = alt ? pad_in[0] : trst_primary_n;

   // interrupt level per pad after synchroniser
   assign lvl = q.s2;

   always_comb begin
      logic [1:0] hit;
      logic [1:0] clr;
      logic [1:0] trg;
      logic [1:0] fn;
      hit = 2'h0;
      clr = 2'h0;
      trg = 2'h0;
      fn = 2'h0;
      d = q;
      d.s1 = pad_in;
      d.s2 = q.s1;
      d.bank_s1 = pin_bank_select;
      d.bank_s2 = q.bank_s1;
      d.prev = q.s2;
      for (int i = 0; i < 2; i++) begin
         fn = spm_fn(q.func, i);
         trg = q.trig[2*i +: 2];
         if (!alt && fn == SPM_FN_IRQ) begin
            case (trg)
               SPM_TRG_LEVEL: hit[i] = !lvl[i]; // active low
               SPM_TRG_RISE: hit[i] = lvl[i] && !q.prev[i];
               SPM_TRG_FALL: hit[i] = !lvl[i] && q.prev[i];
               default: hit[i] = 1'b0;
            endcase
         end
      end
      // bus access, one wait cycle then acknowledge
      d.ack = 1'b0;
      if ((bus_req.read || bus_req.write) && !q.ack) begin
         d.ack = 1'b1;
         if (bus_req.write && bus_req.byteenable[0]) begin
            case (bus_req.address)
               SPM_OFF_FUNC: d.func = bus_req.writedata[3:0];
               SPM_OFF_DIR: d.dir = bus_req.writedata[1:0];
               SPM_OFF_DOUT: d.dout = bus_req.writedata[1:0];
               SPM_OFF_TRIG: d.trig = bus_req.writedata[3:0];
               SPM_OFF_CLR: clr = bus_req.writedata[1:0];
               SPM_OFF_IEN: d.ien = bus_req.writedata[1:0];
               default: clr = 2'h0;
            endcase
         end
         case (bus_req.address)
            SPM_OFF_FUNC: d.rdata = {28'h000_0000, q.func};
            SPM_OFF_DIR: d.rdata = spm_pad2(q.dir);
            SPM_OFF_DOUT: d.rdata = spm_pad2(q.dout);
            SPM_OFF_DIN: d.rdata = spm_pad2(lvl);
            SPM_OFF_TRIG: d.rdata = {28'h000_0000, q.trig};
            SPM_OFF_STAT: d.rdata = spm_pad2(q.stat);
            SPM_OFF_IEN: d.rdata = spm_pad2(q.ien);
            SPM_OFF_PINS: d.rdata = {31'h0000_0000, alt};
            default: d.rdata = SPM_UNMAPPED;
         endcase
      end
      // set wins over clear
      d.stat = (q.stat & ~clr) | hit;
      if (!clk_en) begin
         d = q;
      end
      if (!rst_n) begin
         d = '0;
         d.func = SPM_FUNC_RST;
         d.dir = SPM_DIR_RST;
         d.dout = SPM_DOUT_RST;
         d.trig = SPM_TRIG_RST;
         d.ien = SPM_IEN_RST;
      end
   end

   always_ff @(posedge clk_sys) begin
      q <= d;
   end

   always_comb begin
      irq_event = q.stat;
      irq = |(q.stat & q.ien);
      bus_rsp.readdata = q.rdata;
      bus_rsp.waitrequest = !q.ack;
   end
endmodule : spm_shared_pin_mux

// ---- sim/spm_mux_sva.sv ----
// Purpose: pad routing checks for the shared pin mux
// Assumes: clk_en held high, so bank select settles in two edges
// Notes: bound to the top module at the foot of this file
module spm_mux_sva (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // pads
   input wire logic pin_bank_select,
   input wire logic [1:0] pad_in,
   input wire logic [1:0] pad_out,
   input wire logic [1:0] pad_oe,
   // codec, test port, interrupts
   input wire logic codec_tx_shift_bit,
   input wire logic codec_tx_data_alt_en,
   input wire logic codec_tx_primary_en,
   input wire logic codec_rx_shift_bit,
   input wire logic codec_rx_data_alt_sel,
   input wire logic codec_rx_primary_bit,
   input wire logic trst_primary_n,
   input wire logic tap_trst_n,
   input wire logic [1:0] irq_event,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   import spm_pkg::*;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // three samples cover the two sync stages on the bank select
   sequence s_alt; pin_bank_select [*3]; endsequence
   sequence s_nrm; !pin_bank_select [*3]; endsequence
   property p_tx_one; codec_tx_primary_en == !codec_tx_data_alt_en; endproperty
   property p_tx_pad;
      codec_tx_data_alt_en |-> pad_oe[0] && pad_out[0] == codec_tx_shift_bit;
   endproperty
   property p_rx; codec_rx_shift_bit == (codec_rx_data_alt_sel ?
      pad_in[1] : codec_rx_primary_bit); endproperty
   property p_trst_alt; s_alt |-> tap_trst_n == pad_in[0]; endproperty
   property p_trst_nrm; s_nrm |-> tap_trst_n == trst_primary_n; endproperty
   property p_alt_in; s_alt |-> pad_oe == 2'h0; endproperty
   property p_irq; irq |-> irq_event != 2'h0; endproperty
   property p_rst; $rose(rst_n) |-> pad_oe == 2'h0 && !irq; endproperty
   a_tx_one: assert property (p_tx_one) else $error("tx on two pins");
   a_tx_pad: assert property (p_tx_pad) else $error("tx pad");
   a_rx: assert property (p_rx) else $error("rx route");
   a_trst_alt: assert property (p_trst_alt) else $error("trst alt");
   a_trst_nrm: assert property (p_trst_nrm) else $error("trst main");
   a_alt_in: assert property (p_alt_in) else $error("alt pad driven");
   a_irq: assert property (p_irq) else $error("irq no status");
   a_rst: assert property (p_rst) else $error("pad after reset");
   c_tx: cover property (codec_tx_data_alt_en);
   c_irq: cover property (irq);
   c_trst: cover property (s_alt ##0 !tap_trst_n);
endmodule : spm_mux_sva
bind spm_shared_pin_mux spm_mux_sva u_sva (.*);

// ---- sim/spm_board_model.sv ----
// Purpose: board side of the two shared pads
// Assumes: bench never drives a pad the mux drives
// Notes: a released pad reads high through its pull-up
module spm_board_model (
   // pad wires
   input wire logic [1:0] pad_out,
   input wire logic [1:0] pad_oe,
   input wire logic [1:0] ext_en,
   input wire logic [1:0] ext_val,
   output logic [1:0] pad_in
);
   timeunit 1ns;
   timeprecision 1ns;
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         pad_in[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] : 1'h1;
      end
   end
endmodule : spm_board_model

// ---- sim/spm_shared_pin_mux_test.sv ----
// Purpose: directed bench for the shared pin mux
// Assumes: avalon answer comes within twenty cycles
// Notes: pad six is bit 0, pad seven bit 1
module spm_shared_pin_mux_test;
   timeunit 1ns;
   timeprecision 1ns;
   import spm_pkg::*;
   logic clk_sys = 0, rst_n = 0, clk_en = 1, pin_bank_select = 0;
   logic codec_tx_shift_bit = 0, codec_rx_primary_bit = 0, dsr_level = 0;
   logic trst_primary_n = 1, codec_tx_data_alt_en, codec_tx_primary_en;
   logic codec_rx_shift_bit, codec_rx_data_alt_sel, tap_trst_n, irq;
   logic [1:0] ext_en = 0, ext_val = 0, pad_in, pad_out, pad_oe, irq_event;
   spm_bus_req_t bus_req = '0;
   spm_bus_rsp_t bus_rsp;
   logic [31:0] q;
   int num_errors = 0, compares = 0;
   spm_shared_pin_mux u_dut (.*);
   spm_board_model u_board (.*);
   initial begin forever #20 clk_sys = ~clk_sys; end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic acc(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      bus_req <= '{a, !w, w, d, 4'hF};
      // waitrequest is read at the rising edge, before that edge's updates
      do begin
         @(posedge clk_sys);
         n++;
      end while (bus_rsp.waitrequest !== 1'h0 && n < 20);
      q = bus_rsp.readdata;
      bus_req.read <= 1'h0;
      bus_req.write <= 1'h0;
      if (n >= 20) num_errors++;
   endtask : acc
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      acc(1'h0, a, 32'h0);
      chk(q, exp);
   endtask : rd
   task automatic summarize;
      $display("errors=%0d compares=%0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : summarize
   initial begin #200000; num_errors++; summarize(); end
   initial begin
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'h1;
      rd(SPM_OFF_FUNC, 32'h0);
      rd(SPM_OFF_DIR, 32'h0);
      rd(8'h24, 32'h0);
      acc(1'h1, SPM_OFF_DIR, 32'h1);
      acc(1'h1, SPM_OFF_DOUT, 32'h1);
      ext_en <= 2'h2;
      repeat (4) @(posedge clk_sys);
      rd(SPM_OFF_DIN, 32'h1);
      chk({pad_oe, pad_out[0]}, 32'h3);
      acc(1'h1, SPM_OFF_FUNC, 32'h3);
      for (int v = 0; v < 2; v++) begin
         dsr_level <= 1'(v);
         @(negedge clk_sys);
         chk(pad_out[0], v);
      end
      acc(1'h1, SPM_OFF_FUNC, 32'hA);
      for (int v = 0; v < 2; v++) begin
         codec_tx_shift_bit <= 1'(v);
         codec_rx_primary_bit <= 1'(!v);
         ext_val[1] <= 1'(v);
         @(negedge clk_sys);
         chk({codec_tx_data_alt_en, codec_tx_primary_en, pad_oe[0],
            pad_out[0], codec_rx_data_alt_sel, codec_rx_shift_bit},
            {3'h5, 1'(v), 1'h1, 1'(v)});
      end
      acc(1'h1, SPM_OFF_DIR, 32'h0);
      acc(1'h1, SPM_OFF_FUNC, 32'h5);
      acc(1'h1, SPM_OFF_IEN, 32'h1);
      ext_en <= 2'h3;
      for (int m = 0; m < 3; m++) begin
         acc(1'h1, SPM_OFF_TRIG, 32'(m));
         ext_val <= {1'h1, 1'(m != 1)};
         repeat (4) @(posedge clk_sys);
         acc(1'h1, SPM_OFF_CLR, 32'h3);
         rd(SPM_OFF_STAT, 32'h0);
         ext_val <= {1'h1, 1'(m == 1)};
         repeat (4) @(posedge clk_sys);
         rd(SPM_OFF_STAT, 32'h1);
         chk(irq, 32'h1);
         acc(1'h1, SPM_OFF_IEN, 32'h0);
         @(negedge clk_sys);
         chk(irq, 32'h0);
         acc(1'h1, SPM_OFF_IEN, 32'h1);
         ext_val <= {1'h1, 1'(m != 1)};
         repeat (4) @(posedge clk_sys);
         acc(1'h1, SPM_OFF_CLR, 32'h3);
         rd(SPM_OFF_STAT, 32'h0);
      end
      // a pulse that comes and goes while frozen must leave no trace
      clk_en <= 1'h0;
      ext_val[0] <= 1'h0;
      repeat (4) @(posedge clk_sys);
      ext_val[0] <= 1'h1;
      repeat (2) @(posedge clk_sys);
      clk_en <= 1'h1;
      repeat (4) @(posedge clk_sys);
      rd(SPM_OFF_STAT, 32'h0);
      pin_bank_select <= 1'h1;
      repeat (4) @(posedge clk_sys);
      rd(SPM_OFF_PINS, 32'h1);
      for (int v = 0; v < 2; v++) begin
         ext_val[0] <= 1'(v);
         trst_primary_n <= 1'(!v);
         @(negedge clk_sys);
         chk({pad_oe, tap_trst_n}, v);
      end
      pin_bank_select <= 1'h0;
      trst_primary_n <= 1'h0;
      repeat (4) @(posedge clk_sys);
      chk(tap_trst_n, 32'h0);
      rst_n <= 1'h0;
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'h1;
      rd(SPM_OFF_FUNC, 32'h0);
      summarize();
   end
endmodule : spm_shared_pin_mux_test
